// ===== hw/scf_ctrl.v
// sensor frame readout, exposure and context control with apb registers
//
// Function
// - default first pixel is column 10, row 14
// - read rows in order, one row at a time
// - mirrored readout starts on same colour
// - power up in two-exposure hdr mode
// - long and short reset pointers interleaved
// - buffer long line, combine to 16 bits
// - exposure ratio 4x, 8x, 16x or 32x
// - output 16-bit, tone-mapped or companded 12/14
// - long only, short only or interleaved
// - equal reset-to-read time for every row; next-frame rows get the long reset in hdr mode only, never the short one
// - exposure changes only between whole frames
// - global reset drives mechanical shutter control
// - two register-data rows before image
// - two statistics rows after image
// - slave mode frame starts on trigger
// - 256 x 16 context memory for registers
// - select bit chooses set a or b
// - new exposure frame n+1, rest n+2
// - twenty duplicated a/b context registers
// - motion correction only when enabled
// - colour noise filter, gain-aware same-plane
// - shutter output pin, always driven, high during global-reset exposure
`timescale 1ns/1ps
`include "scf_defs.vh"
module scf_ctrl (
    input wire CLK_SYS,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire TRIGGER,
    output reg SHUTTER,
    output reg GRST_ALL,
    output reg RST_ROW_STB,
    output reg RST_ROW_SHORT,
    output reg [11:0] RST_ROW_ADDR,
    output reg FRAME_VALID,
    output reg LINE_VALID,
    output reg [15:0] DOUT
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_WAIT = 5'b00010;
    localparam ST_GREXP = 5'b00100;
    localparam ST_FRAME = 5'b01000;
    localparam ST_LOAD = 5'b10000;

    reg [15:0] ctx_a [0:19];
    reg [15:0] ctx_b [0:19];
    reg [15:0] ctrl_reg;
    reg [15:0] tune_reg;
    reg [16:0] cmload_reg;
    reg [7:0] cm_addr_reg;
    reg gr_go_reg;
    reg [5:0] ld_idx_reg;
    reg [4:0] state_reg;
    reg trig_s1_reg, trig_s2_reg, trig_s3_reg;
    reg exp_sel_reg, oth_sel_reg, frz_reg;
    reg [15:0] act_exp_reg, pend_exp_reg;
    reg [11:0] k_reg;
    reg [15:0] pck_reg;
    reg ph_reg;
    reg [31:0] gr_cnt_reg;
    reg [8:0] ld_cnt_reg;
    reg [15:0] frame_cnt_reg;
    reg [31:0] sum_reg;
    reg [15:0] max_reg;
    reg v1_reg, fv1_reg, r1_reg;
    reg [1:0] kind1_reg;
    reg [11:0] x1_reg, y1_reg, c1_reg;
    reg [15:0] prev1_reg, prev2_reg;
    integer i;

    function [15:0] rstv;
        input integer n;
        begin
            case (n)
                0: rstv = `SCF_R_EXP;
                1: rstv = `SCF_R_LLEN;
                2: rstv = `SCF_R_FLEN;
                7: rstv = `SCF_R_XS;
                8: rstv = `SCF_R_YS;
                9: rstv = `SCF_R_XE;
                10: rstv = `SCF_R_YE;
                11, 12: rstv = `SCF_R_ODD;
                5, 6, 13, 14, 15, 16, 17: rstv = `SCF_R_GAIN;
                18: rstv = `SCF_R_OPM;
                default: rstv = 16'h0000;
            endcase
        end
    endfunction

    function [15:0] getc;
        input sel;
        input [4:0] n;
        begin
            getc = sel ? ctx_b[n] : ctx_a[n];
        end
    endfunction

    function [11:0] getc12;
        input sel;
        input [4:0] n;
        begin
            getc12 = sel ? ctx_b[n][11:0] : ctx_a[n][11:0];
        end
    endfunction

    function [11:0] first;
        input [11:0] s, e;
        input mir;
        begin
            if (!mir) first = s;
            else if (s[0] ^ e[0]) first = e + 12'h001;
            else first = e;
        end
    endfunction

    function [11:0] lng;
        input [15:0] sc;
        begin
            lng = (|sc[15:12]) ? 12'hFFF : sc[11:0];
        end
    endfunction

    function [11:0] sht;
        input [15:0] sc;
        input [1:0] r;
        reg [15:0] t;
        begin
            t = sc >> ({1'b0, r} + 3'h2);
            sht = (|t[15:12]) ? 12'hFFF : t[11:0];
        end
    endfunction

    function [16:0] absd;
        input [15:0] a, b;
        begin
            absd = (a > b) ? {1'b0, a - b} : {1'b0, b - a};
        end
    endfunction

    function [15:0] comb;
        input [11:0] l, s;
        input [1:0] r;
        input mc;
        input [15:0] thr;
        reg [20:0] se;
        reg [15:0] sv;
        begin
            se = {9'h000, s} << ({1'b0, r} + 3'h2);
            sv = (|se[20:16]) ? 16'hFFFF : se[15:0];
            if (l < `SCF_SAT && !(mc && absd({4'h0, l}, sv) > thr))
                comb = {4'h0, l};
            else
                comb = sv;
        end
    endfunction

    function [15:0] gain;
        input [15:0] v, g1, g2;
        reg [47:0] p;
        begin
            p = v * g1 * g2;
            gain = (|p[47:30]) ? 16'hFFFF : p[29:14];
        end
    endfunction

    function [15:0] cmp;
        input [15:0] v;
        input w14;
        begin
            if (w14)
                cmp = (v < 16'h2000) ? v : 16'h2000 + ((v - 16'h2000) >> 3);
            else if (v < 16'h0800)
                cmp = v;
            else if (v < 16'h4000)
                cmp = 16'h0800 + ((v - 16'h0800) >> 3);
            else
                cmp = 16'h0F00 + ((v - 16'h4000) >> 8);
        end
    endfunction

    // live geometry from the non-exposure context
    wire csel = ctrl_reg[`SCF_B_CTXSEL];
    wire [15:0] llen = getc(oth_sel_reg, `SCF_X_LLEN);
    wire [15:0] flen = getc(oth_sel_reg, `SCF_X_FLEN);
    wire [11:0] xs = getc12(oth_sel_reg, `SCF_X_XS);
    wire [11:0] ys = getc12(oth_sel_reg, `SCF_X_YS);
    wire [11:0] xe = getc12(oth_sel_reg, `SCF_X_XE);
    wire [11:0] ye = getc12(oth_sel_reg, `SCF_X_YE);
    wire [15:0] opm = getc(oth_sel_reg, `SCF_X_OPM);
    wire byp = getc(oth_sel_reg, `SCF_X_BYP) != 16'h0000;
    wire hdr = opm[0];
    wire [1:0] rat = opm[2:1];
    wire [2:0] fmt = opm[5:3];
    wire embd = ctrl_reg[`SCF_B_EMBD];
    wire embs = ctrl_reg[`SCF_B_EMBS];
    wire [11:0] ny = ye - ys + 12'h001;
    wire [11:0] nx = xe - xs + 12'h001;
    wire [11:0] off = embd ? `SCF_EXTRA_ROWS : 12'h000;
    wire [11:0] act_end = off + ny;
    wire [11:0] vis = act_end + (embs ? `SCF_EXTRA_ROWS : 12'h000);
    wire is_emb = k_reg < off;
    wire is_act = k_reg >= off && k_reg < act_end;
    wire is_stat = k_reg >= act_end && k_reg < vis;
    wire in_fr = state_reg == ST_FRAME;
    wire two_ph = hdr & is_act;
    wire last_ph = ~two_ph | ph_reg;
    wire col_ok = pck_reg < {4'h0, nx};
    wire line_end = pck_reg == llen - 16'h0001;
    wire fr_end = in_fr && line_end && last_ph && k_reg == flen[11:0] - 12'h001;
    wire [11:0] fy = first(ys, ye, ctrl_reg[`SCF_B_MIRV]);
    wire [11:0] fx = first(xs, xe, ctrl_reg[`SCF_B_MIRH]);
    wire [11:0] arow = k_reg - off;
    wire [11:0] ycur = ctrl_reg[`SCF_B_MIRV] ? fy - arow : fy + arow;
    wire [11:0] xcur = ctrl_reg[`SCF_B_MIRH] ? fx - pck_reg[11:0] :
        fx + pck_reg[11:0];
    wire [15:0] scene = {ycur[7:0], xcur[7:0]};

    // reset pointers run ahead of the read pointer
    wire [15:0] pend = frz_reg ? pend_exp_reg : getc(csel, `SCF_X_EXP);
    wire [15:0] sh_exp = act_exp_reg >> ({1'b0, rat} + 3'h2);
    wire [15:0] t_in = {4'h0, k_reg} + act_exp_reg;
    wire [15:0] t_wr = {4'h0, k_reg} + pend;
    wire [15:0] t_sh = {4'h0, k_reg} + sh_exp;
    wire [15:0] t_sel = (pck_reg == 16'h0001) ? t_in :
        (pck_reg == 16'h0002) ? t_wr - flen : t_sh;
    wire t_ok = (pck_reg == 16'h0002) ? t_wr >= flen : t_sel < flen;
    wire [11:0] t_row = t_sel[11:0] - off;
    wire t_act = t_sel[11:0] >= off && t_sel[11:0] < act_end;

    // state and loader helpers
    wire ld_pend = cmload_reg[`SCF_B_LDGO];
    wire ld_done = state_reg == ST_LOAD &&
        ld_cnt_reg == {cmload_reg[15:8], 1'b0};
    wire ld_wr = state_reg == ST_LOAD && ld_cnt_reg != 9'h000 &&
        !ld_cnt_reg[0];
    wire streaming = ctrl_reg[`SCF_B_STREAM];
    wire grmode = ctrl_reg[`SCF_B_GRMODE];
    wire idle_go = state_reg == ST_IDLE && !ld_pend && streaming;
    wire gr_take = idle_go && grmode && gr_go_reg;
    wire trig_rise = trig_s2_reg & ~trig_s3_reg;
    wire start_fr = (idle_go && !grmode && !ctrl_reg[`SCF_B_SLAVE]) ||
        (state_reg == ST_WAIT && trig_rise) ||
        (state_reg == ST_GREXP && gr_cnt_reg == 32'h0000_0000);

    // memories
    wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
    wire [15:0] cm_rdata;
    wire [11:0] lb_rdata;
    wire [7:0] cm_raddr = (state_reg == ST_LOAD) ?
        cmload_reg[7:0] + ld_cnt_reg[7:0] : cm_addr_reg;
    scf_mem #(.AW(`SCF_CM_AW), .DW(`SCF_CM_DW)) u_ctxmem (
        .clk(CLK_SYS),
        .we(apb_wr && PADDR == `SCF_A_CMDATA),
        .waddr(cm_addr_reg),
        .wdata(PWDATA[15:0]),
        .raddr(cm_raddr),
        .rdata(cm_rdata)
    );
    scf_mem #(.AW(`SCF_LB_AW), .DW(`SCF_LB_DW)) u_linebuf (
        .clk(CLK_SYS),
        .we(in_fr && two_ph && !ph_reg && col_ok),
        .waddr(pck_reg[10:0]),
        .wdata(lng(scene)),
        .raddr(pck_reg[10:0]),
        .rdata(lb_rdata)
    );

    // apb decode
    wire ctx_hit = PADDR >= `SCF_A_CTXA && PADDR < `SCF_A_CTXEND;
    wire ctx_b_hit = PADDR >= `SCF_A_CTXB;
    wire [7:0] ctx_off = PADDR - (ctx_b_hit ? `SCF_A_CTXB : `SCF_A_CTXA);
    wire [4:0] ctx_i = ctx_off[6:2];
    wire map_hit = PADDR[1:0] == 2'h0 && (ctx_hit || PADDR <= `SCF_A_TUNE);
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h0000_0000;
        case (PADDR)
            `SCF_A_CTRL: rd_word = {16'h0000, ctrl_reg};
            `SCF_A_STAT: rd_word = {frame_cnt_reg, 6'h00, ld_pend, gr_go_reg,
                state_reg, oth_sel_reg, exp_sel_reg, FRAME_VALID};
            `SCF_A_CMADDR: rd_word = {24'h00_0000, cm_addr_reg};
            `SCF_A_CMDATA: rd_word = {16'h0000, cm_rdata};
            `SCF_A_CMLOAD: rd_word = {15'h0000, cmload_reg};
            `SCF_A_TUNE: rd_word = {16'h0000, tune_reg};
            default: if (ctx_hit) rd_word = {16'h0000, getc(ctx_b_hit, ctx_i)};
        endcase
    end

    // register file, context sets and memory loader
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            for (i = 0; i < `SCF_NCTX; i = i + 1) begin
                ctx_a[i] <= rstv(i);
                ctx_b[i] <= rstv(i);
            end
            ctrl_reg <= `SCF_CTRL_RST;
            tune_reg <= `SCF_TUNE_RST;
            cmload_reg <= 17'h0_0000;
            cm_addr_reg <= 8'h00;
            gr_go_reg <= 1'b0;
            ld_idx_reg <= 6'h00;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY &
                ~(PADDR == `SCF_A_CMDATA && state_reg == ST_LOAD);
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~map_hit;
            if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
                PRDATA <= map_hit ? rd_word : 32'h0000_0000;
            end
            if (ld_wr && ld_idx_reg[4:0] < `SCF_NCTX) begin
                if (ld_idx_reg[5]) ctx_b[ld_idx_reg[4:0]] <= cm_rdata;
                else ctx_a[ld_idx_reg[4:0]] <= cm_rdata;
            end
            if (state_reg == ST_LOAD && ld_cnt_reg[0]) begin
                ld_idx_reg <= cm_rdata[5:0];
            end
            if (ld_done) begin
                cmload_reg[`SCF_B_LDGO] <= 1'b0;
            end
            if (gr_take) begin
                gr_go_reg <= 1'b0;
            end
            if (apb_wr && map_hit) begin
                case (PADDR)
                    `SCF_A_CTRL: ctrl_reg <= PWDATA[15:0];
                    `SCF_A_CMADDR: cm_addr_reg <= PWDATA[7:0];
                    `SCF_A_CMDATA: cm_addr_reg <= cm_addr_reg + 8'h01;
                    `SCF_A_CMLOAD: cmload_reg <= PWDATA[16:0];
                    `SCF_A_GRST: gr_go_reg <= PWDATA[0] |
                        (gr_go_reg & ~gr_take);
                    `SCF_A_TUNE: tune_reg <= PWDATA[15:0];
                    default: if (ctx_hit && ctx_i < `SCF_NCTX) begin
                        if (ctx_b_hit) ctx_b[ctx_i] <= PWDATA[15:0];
                        else ctx_a[ctx_i] <= PWDATA[15:0];
                    end
                endcase
            end
        end
    end

    // frame sequencer
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
            exp_sel_reg <= 1'b0;
            oth_sel_reg <= 1'b0;
            frz_reg <= 1'b0;
            act_exp_reg <= `SCF_R_EXP;
            pend_exp_reg <= `SCF_R_EXP;
            k_reg <= 12'h000;
            pck_reg <= 16'h0000;
            ph_reg <= 1'b0;
            gr_cnt_reg <= 32'h0000_0000;
            ld_cnt_reg <= 9'h000;
            frame_cnt_reg <= 16'h0000;
            SHUTTER <= 1'b0;
            GRST_ALL <= 1'b0;
            RST_ROW_STB <= 1'b0;
            RST_ROW_SHORT <= 1'b0;
            RST_ROW_ADDR <= 12'h000;
        end else begin
            trig_s1_reg <= TRIGGER;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
            GRST_ALL <= gr_take;
            RST_ROW_STB <= in_fr && last_ph && t_ok && t_act &&
                pck_reg >= 16'h0001 && pck_reg <= {14'h0000, hdr, 1'b1};
            RST_ROW_SHORT <= pck_reg == 16'h0003;
            RST_ROW_ADDR <= ctrl_reg[`SCF_B_MIRV] ? fy - t_row : fy + t_row;
            if (start_fr) begin
                exp_sel_reg <= csel;
                oth_sel_reg <= exp_sel_reg;
                act_exp_reg <= pend;
                frz_reg <= 1'b0;
                k_reg <= 12'h000;
                pck_reg <= 16'h0000;
                ph_reg <= 1'b0;
                SHUTTER <= 1'b0;
                state_reg <= ST_FRAME;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        ld_cnt_reg <= 9'h000;
                        if (ld_pend) state_reg <= ST_LOAD;
                        else if (gr_take) begin
                            gr_cnt_reg <= getc(csel, `SCF_X_EXP) * llen;
                            SHUTTER <= 1'b1;
                            state_reg <= ST_GREXP;
                        end else if (idle_go && ctrl_reg[`SCF_B_SLAVE])
                            state_reg <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (!ctrl_reg[`SCF_B_SLAVE]) state_reg <= ST_IDLE;
                    end
                    ST_GREXP: gr_cnt_reg <= gr_cnt_reg - 32'h0000_0001;
                    ST_LOAD: begin
                        ld_cnt_reg <= ld_cnt_reg + 9'h001;
                        if (ld_done) state_reg <= ST_IDLE;
                    end
                    ST_FRAME: begin
                        if (!frz_reg && pck_reg == 16'h0000 && t_wr >= flen) begin
                            frz_reg <= 1'b1;
                            pend_exp_reg <= pend;
                        end
                        if (!line_end) pck_reg <= pck_reg + 16'h0001;
                        else begin
                            pck_reg <= 16'h0000;
                            ph_reg <= ~last_ph;
                            if (last_ph) k_reg <= k_reg + 12'h001;
                        end
                        if (fr_end) begin
                            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // pixel path, stage one values
    wire [15:0] sc1 = {y1_reg[7:0], x1_reg[7:0]};
    wire [11:0] l1 = hdr ? lb_rdata : lng(sc1);
    wire [11:0] s1 = sht(sc1, rat);
    wire [15:0] mthr = {4'h0, tune_reg[7:0], 4'h0};
    wire [15:0] cmb = (hdr && !byp) ?
        comb(l1, s1, rat, ctrl_reg[`SCF_B_MOTION], mthr) : {4'h0, l1};
    wire [4:0] gi = `SCF_X_G1 + {3'h0, y1_reg[0], x1_reg[0]};
    wire [15:0] gv = gain(cmb, getc(oth_sel_reg, gi),
        getc(oth_sel_reg, `SCF_X_GG));
    wire [15:0] cg = getc(oth_sel_reg, `SCF_X_CGAIN);
    wire [12:0] nprod = {5'h00, tune_reg[15:8]} *
        {8'h00, {1'b0, cg[3:0]} + 5'h01};
    wire [16:0] nthr = {4'h0, nprod};
    wire [16:0] nsum = {1'b0, gv} + {1'b0, prev2_reg};
    wire [15:0] nv = (ctrl_reg[`SCF_B_NOISE] && absd(gv, prev2_reg) < nthr) ?
        nsum[16:1] : gv;
    reg [15:0] pix;
    always @* begin
        case (fmt)
            `SCF_F_TONE: pix = {4'h0, nv[15:4]};
            `SCF_F_C12: pix = cmp(nv, 1'b0);
            `SCF_F_C14: pix = cmp(nv, 1'b1);
            `SCF_F_LONG: pix = {4'h0, l1};
            `SCF_F_SHORT: pix = {4'h0, s1};
            `SCF_F_ILV: pix = {4'h0, c1_reg[0] ? s1 : l1};
            default: pix = nv;
        endcase
    end
    wire [15:0] embw = r1_reg ? ((c1_reg == 12'h000) ? frame_cnt_reg :
        (c1_reg == 12'h001) ? act_exp_reg : ctrl_reg) :
        ((c1_reg < 12'd20) ? getc(oth_sel_reg, c1_reg[4:0]) : 16'h0000);
    wire [15:0] statw = r1_reg ? max_reg :
        (c1_reg[0] ? sum_reg[15:0] : sum_reg[31:16]);

    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            v1_reg <= 1'b0;
            fv1_reg <= 1'b0;
            r1_reg <= 1'b0;
            kind1_reg <= 2'h0;
            x1_reg <= 12'h000;
            y1_reg <= 12'h000;
            c1_reg <= 12'h000;
            prev1_reg <= 16'h0000;
            prev2_reg <= 16'h0000;
            sum_reg <= 32'h0000_0000;
            max_reg <= 16'h0000;
            FRAME_VALID <= 1'b0;
            LINE_VALID <= 1'b0;
            DOUT <= 16'h0000;
        end else begin
            v1_reg <= in_fr && last_ph && col_ok && k_reg < vis;
            // frame valid opens with the first visible line
            fv1_reg <= in_fr && k_reg < vis &&
                !(k_reg == 12'h000 && two_ph && !ph_reg);
            kind1_reg <= {is_stat, is_emb};
            r1_reg <= is_emb ? k_reg[0] : ~(k_reg[0] ^ act_end[0]);
            x1_reg <= xcur;
            y1_reg <= ycur;
            c1_reg <= pck_reg[11:0];
            FRAME_VALID <= fv1_reg;
            LINE_VALID <= v1_reg;
            if (!v1_reg) DOUT <= 16'h0000;
            else if (kind1_reg[0]) DOUT <= embw;
            else if (kind1_reg[1]) DOUT <= statw;
            else DOUT <= pix;
            if (start_fr) begin
                sum_reg <= 32'h0000_0000;
                max_reg <= 16'h0000;
            end else if (v1_reg && kind1_reg == 2'h0) begin
                prev1_reg <= nv;
                prev2_reg <= prev1_reg;
                sum_reg <= sum_reg + {16'h0000, pix};
                if (pix > max_reg) max_reg <= pix;
            end
        end
    end
endmodule

// ===== hw/scf_defs.vh
// register map, field positions, reset values and fixed counts
`ifndef SCF_DEFS_VH
`define SCF_DEFS_VH
`define SCF_A_CTRL 8'h00
`define SCF_A_STAT 8'h04
`define SCF_A_CMADDR 8'h08
`define SCF_A_CMDATA 8'h0C
`define SCF_A_CMLOAD 8'h10
`define SCF_A_GRST 8'h14
`define SCF_A_TUNE 8'h18
`define SCF_A_CTXA 8'h40
`define SCF_A_CTXB 8'h90
`define SCF_A_CTXEND 8'hE0
`define SCF_B_STREAM 0
`define SCF_B_SLAVE 1
`define SCF_B_GRMODE 2
`define SCF_B_EMBD 3
`define SCF_B_EMBS 4
`define SCF_B_CTXSEL 5
`define SCF_B_MOTION 6
`define SCF_B_NOISE 7
`define SCF_B_MIRH 8
`define SCF_B_MIRV 9
`define SCF_B_LDGO 16
`define SCF_CTRL_RST 16'h0001
`define SCF_TUNE_RST 16'h0410
`define SCF_NCTX 20
`define SCF_X_EXP 5'h00
`define SCF_X_LLEN 5'h01
`define SCF_X_FLEN 5'h02
`define SCF_X_CGAIN 5'h06
`define SCF_X_XS 5'h07
`define SCF_X_YS 5'h08
`define SCF_X_XE 5'h09
`define SCF_X_YE 5'h0A
`define SCF_X_G1 5'h0D
`define SCF_X_GG 5'h11
`define SCF_X_OPM 5'h12
`define SCF_X_BYP 5'h13
`define SCF_R_EXP 16'h0010
`define SCF_R_LLEN 16'h0800
`define SCF_R_FLEN 16'h0460
`define SCF_R_XS 16'h000A
`define SCF_R_YS 16'h000E
`define SCF_R_XE 16'h0791
`define SCF_R_YE 16'h044D
`define SCF_R_GAIN 16'h0080
`define SCF_R_OPM 16'h0005
`define SCF_R_ODD 16'h0001
`define SCF_F_TONE 3'h1
`define SCF_F_C12 3'h2
`define SCF_F_C14 3'h3
`define SCF_F_LONG 3'h4
`define SCF_F_SHORT 3'h5
`define SCF_F_ILV 3'h6
`define SCF_EXTRA_ROWS 12'h002
`define SCF_SAT 12'hF00
`define SCF_LB_AW 11
`define SCF_LB_DW 12
`define SCF_CM_AW 8
`define SCF_CM_DW 16
`endif

// ===== hw/scf_mem.v
// simple dual-port memory with registered read data
`timescale 1ns/1ps
module scf_mem #(
    parameter AW = 8,
    parameter DW = 16
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ===== testbench/scf_ctrl_asserts.sv
// concurrent checks on the controller ports
`timescale 1ns/1ps
module scf_ctrl_asserts (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic GRST_ALL,
    input wire logic FRAME_VALID,
    input wire logic LINE_VALID,
    input wire logic [15:0] DOUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sequence setup_then_access;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    a_ready_bounded: assert property (setup_then_access |-> ##[1:64] PREADY)
        else $error("access not answered");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("pready outside an access");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    a_line_in_frame: assert property (LINE_VALID |-> FRAME_VALID)
        else $error("line valid outside frame");
    a_dout_quiet: assert property (!LINE_VALID |-> DOUT == 16'h0000)
        else $error("data outside a line");
    a_frame_gap: assert property ($fell(FRAME_VALID) |-> !FRAME_VALID [*2])
        else $error("frames too close");
    a_frame_opens: assert property ($rose(FRAME_VALID) |-> LINE_VALID)
        else $error("frame opened without line");
    a_grst_pulse: assert property (GRST_ALL |=> !GRST_ALL)
        else $error("global reset pulse too long");
endmodule

// ===== testbench/scf_ctrl_test.sv
// testbench for the frame readout and context controller
`timescale 1ns/1ps
module scf_ctrl_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig_go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata, pwv;
    logic pready, pslverr, rerr, trigger, frame_valid, line_valid;
    logic shutter, grst_all;
    logic [15:0] dout;
    logic [7:0] ra [7] = '{8'h00, 8'h18, 8'h88, 8'hD8, 8'h5C, 8'h60, 8'h40};
    logic [15:0] rv [7] = '{16'h0001, 16'h0410, 16'h0005, 16'h0005,
        16'h000A, 16'h000E, 16'h0010};
    int n_errors = 0, checks_done = 0, cycles = 0, n;
    always #12.5 clk_sys = ~clk_sys;
    scf_ctrl scf_ctrl_i (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TRIGGER(trigger), .SHUTTER(shutter), .GRST_ALL(grst_all),
        .RST_ROW_STB(),
        .RST_ROW_SHORT(), .RST_ROW_ADDR(), .FRAME_VALID(frame_valid),
        .LINE_VALID(line_valid), .DOUT(dout));
    scf_trig_src scf_trig_src_i (.go(trig_go), .trigger(trigger));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0000_0000);
            chk(rdata, {16'h0000, rv[i]});
        end
        apb(1'b1, 8'h22, 32'h0000_FFFF);
        chk({31'h0, rerr}, 32'h0000_0001);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({rerr, rdata[30:0]}, 32'h8000_0000);
        for (int f = 0; f < 7; f++) begin
            pwv = {26'h0, f[2:0], f[1:0], 1'b1};
            apb(1'b1, 8'hD8, pwv);
            apb(1'b0, 8'hD8, 32'h0000_0000);
            chk(rdata, pwv);
        end
        apb(1'b1, 8'h08, 32'h0000_00FE);
        apb(1'b1, 8'h0C, 32'h0000_0000);
        apb(1'b1, 8'h0C, 32'h0000_1234);
        apb(1'b1, 8'h08, 32'h0000_00FF);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk(rdata, 32'h0000_1234);
        trig_go <= 1'b1;
        while (line_valid !== 1'b1) @(posedge clk_sys);
        n = 0;
        while (line_valid === 1'b1) begin
            if (n < 3) chk({16'h0000, dout}, 32'h0000_0E0A + n);
            n++;
            @(posedge clk_sys);
        end
        chk(n, 32'h0000_0788);
        trig_go <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        apb(1'b1, 8'h44, 32'h0000_0010);
        apb(1'b1, 8'h48, 32'h0000_0008);
        apb(1'b1, 8'h64, 32'h0000_000D);
        apb(1'b1, 8'h68, 32'h0000_0010);
        apb(1'b1, 8'h00, 32'h0000_0005);
        apb(1'b1, 8'h14, 32'h0000_0001);
        while (grst_all !== 1'b1) @(posedge clk_sys);
        chk({31'h0, shutter}, 32'h0000_0001);
        n = 0;
        while (shutter === 1'b1) begin
            n++;
            @(posedge clk_sys);
        end
        chk(n, 32'h0000_0101);
        apb(1'b1, 8'h00, 32'h0000_0000);
        repeat (250) @(posedge clk_sys);
        apb(1'b1, 8'h00, 32'h0000_000B);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk({24'h0, rdata[7:0]}, 32'h0000_0010);
        trig_go <= 1'b1;
        while (line_valid !== 1'b1) @(posedge clk_sys);
        chk({16'h0000, dout}, 32'h0000_0010);
        repeat (2) @(posedge clk_sys);
        chk({16'h0000, dout}, 32'h0000_0008);
        summarize();
    end
endmodule
bind scf_ctrl scf_ctrl_asserts scf_ctrl_asserts_i (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .GRST_ALL(GRST_ALL), .FRAME_VALID(FRAME_VALID),
    .LINE_VALID(LINE_VALID), .DOUT(DOUT));

// ===== testbench/scf_trig_src.sv
// trigger source standing in for the external controller
`timescale 1ns/1ps
module scf_trig_src (
    input wire logic go,
    output logic trigger
);
    logic link_clk = 1'b0;
    initial trigger = 1'b0;
    // link clock only runs while triggering
    always #100 link_clk = go ? ~link_clk : 1'b0;
    always @(posedge link_clk) begin
        trigger <= ~trigger;
    end
endmodule
